// >>> lcs_pkg.sv
// package: register map, field layout and timing counts for the link control block
package lcs_pkg;
  localparam logic [7:0]  LCS_LINK_CONTROL_OFF = 8'h84;
  localparam logic [7:0]  LCS_LINK_STATUS_OFF  = 8'h88;
  localparam logic [31:0] LCS_RSV_MASK         = 32'hF888_0CC5;
  localparam int LCS_RX_WIDTH_LSB   = 24;
  localparam int LCS_TX_LIMIT_LSB   = 20;
  localparam int LCS_RX_LIMIT_LSB   = 16;
  localparam int LCS_WIDE_ADDR_BIT  = 15;
  localparam int LCS_LONG_CTL_BIT   = 14;
  localparam int LCS_FLOAT_EN_BIT   = 13;
  localparam int LCS_ISO_EN_BIT     = 12;
  localparam int LCS_CHK_ERR_LSB    = 8;
  localparam int LCS_INIT_DONE_BIT  = 5;
  localparam int LCS_LINK_FAIL_BIT  = 4;
  localparam int LCS_CORRUPT_BIT    = 3;
  localparam int LCS_FLOOD_EN_BIT   = 1;
  localparam logic [2:0] LCS_W16    = 3'h1;
  localparam logic [2:0] LCS_W8     = 3'h0;
  localparam logic [2:0] LCS_WNC    = 3'h7;
  localparam logic       LCS_FLAG_RST = 1'b0;
  localparam logic [1:0] LCS_ERR_RST  = 2'h0;
  // control hold times
  localparam int LCS_CLK_HZ        = 20_000_000;
  localparam int LCS_SHORT_HOLD_NS = 800;    // at least 16 bit times at slowest 200 MHz link
  localparam int LCS_LONG_HOLD_US  = 50;
  localparam int LCS_SHORT_CYC = (LCS_SHORT_HOLD_NS * (LCS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int LCS_LONG_CYC  = LCS_LONG_HOLD_US * (LCS_CLK_HZ / 1_000_000);
  localparam int LCS_HOLD_W    = 11;
endpackage

// >>> lcs_ctl_hold.sv
// control-hold timer run during initialisation after a stop release
`timescale 1ns/1ps
`default_nettype none
module lcs_ctl_hold (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  // control
  input  wire logic                      start,
  input  wire logic [lcs_pkg::LCS_HOLD_W-1:0] hold_cycles,
  // status
  output logic                           hold_active,
  output logic                           hold_done
);
  import lcs_pkg::*;
  logic [LCS_HOLD_W-1:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_reg     <= '0;
      hold_active <= 1'b0;
      hold_done   <= 1'b0;
    end else if (clk_en) begin
      hold_done <= 1'b0;
      if (start) begin
        cnt_reg     <= hold_cycles;
        hold_active <= 1'b1;
      end else if (hold_active) begin
        if (cnt_reg <= LCS_HOLD_W'(1)) begin
          hold_active <= 1'b0;
          hold_done   <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - LCS_HOLD_W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> lcs_link_ctrl.sv
// link control and status register block with init sequencing
// How it works
// (RULE1) rx_width_sel is a writable 3-bit field, cold reset from negotiated width.
// (RULE2) sixteen-bit width write refused unless link is ganged.
// (RULE3) width writes ignored when link was found disconnected at cold reset.
// (RULE4) written width only applied at warm reset or stop disconnect.
// (RULE5) tx_width_limit reads 8 or 16 by version, 8 when unganged.
// (RULE6) rx_width_limit reads 8 or 16 by version, 8 when unganged.
// (RULE7) wide_addr_pkt_en bit, cold reset zero, drives wide address output.
// (RULE8) control held 16 bit times or about 50 us after peer control seen.
// (RULE9) long_ctl_hold ignored at third generation rate; cold reset zero.
// (RULE10) disconnect_float_en floats transmitters in disconnect; ignored at third gen.
// (RULE11) firmware should set disconnect_float_en during configuration.
// (RULE12) iso_flow_en bit selects flow mode, applied at next warm reset.
// (RULE13) software keeps all coherent links in the same flow mode.
// (RULE14) two lane_check_err bits, set by hardware, write one clears.
// (RULE15) lane error sets bit; in retry mode uncorrectable error sets low bit.
// (RULE16) link_init_done set on successful init, clear without healthy peer.
// (RULE17) link_init_done survives disconnects and retries; zero in test modes.
// (RULE18) link failure set by flood CRC, failed reconnect, sync flood, unused.
// (RULE19) check_corrupt_inject makes transmitter send wrong check values.
// (RULE20) width codes: 001 sixteen, 000 eight, 111 not connected.
// (RULE21) with check_flood_en, a lane error floods sync and sets link failure.
// (RULE22) reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module lcs_link_ctrl (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        cold_rst,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // configuration straps
  input  wire logic        link_ganged,
  input  wire logic        wide_version,
  input  wire logic [2:0]  negotiated_width,
  input  wire logic        third_gen_rate,
  input  wire logic        link_unused,
  // link events
  input  wire logic        link_stop_n,
  input  wire logic        peer_ctl_in,
  input  wire logic        retry_mode,
  input  wire logic [1:0]  lane_err_in,
  input  wire logic        uncorrectable_err,
  input  wire logic        reconnect_fail,
  input  wire logic        sync_flood_rx,
  input  wire logic        init_ok,
  input  wire logic        test_mode,
  // link controls
  output logic [2:0]       rx_width_active,
  output logic             iso_flow_mode,
  output logic             wide_addr_pkt_en,
  output logic             link_ctl_sig,
  output logic             tx_float,
  output logic             check_corrupt_inject,
  output logic             sync_flood_tx
);
  import lcs_pkg::*;

  // synchronised pin inputs
  logic [1:0] stop_s_reg, ctl_s_reg;
  logic       stop_q_reg;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stop_s_reg <= 2'h3;
      ctl_s_reg  <= 2'h0;
      stop_q_reg <= 1'b1;
    end else if (clk_en) begin
      stop_s_reg <= {stop_s_reg[0], link_stop_n};
      ctl_s_reg  <= {ctl_s_reg[0], peer_ctl_in};
      stop_q_reg <= stop_s_reg[1];
    end
  end
  logic stop_fall, stop_rise, stop_asserted;
  assign stop_asserted = ~stop_s_reg[1];
  assign stop_fall     = stop_q_reg & ~stop_s_reg[1];
  assign stop_rise     = ~stop_q_reg & stop_s_reg[1];

  // bus decode, one wait state per access
  logic ack_reg;
  logic hit_ctl, hit_sts, wr_en, rd_en;
  always_ff @(posedge core_clk) begin
    if (sys_rst) ack_reg <= 1'b0;
    else if (clk_en) ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end
  assign avs_waitrequest = ~ack_reg;
  assign hit_ctl = (avs_address == LCS_LINK_CONTROL_OFF);
  assign hit_sts = (avs_address == LCS_LINK_STATUS_OFF);
  assign wr_en   = avs_write & ack_reg & clk_en;
  assign rd_en   = avs_read & ~ack_reg & clk_en;

  logic [31:0] wmask;
  always_comb begin
    for (int i = 0; i < 4; i++) wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
  end
  logic [31:0] wd;
  assign wd = avs_writedata & wmask;
  logic ctl_wr;
  assign ctl_wr = wr_en & hit_ctl;

  // cold-reset capture of negotiated width and disconnect state
  logic [2:0] rx_width_reg;
  logic       disc_at_cold_reg;
  logic       cold_seen_reg;
  logic       width_upd;
  assign width_upd = ctl_wr & avs_byteenable[3] & ~disc_at_cold_reg // see RULE3
                   & ~((wd[26:24] == LCS_W16) & ~link_ganged);      // see RULE2
  always_ff @(posedge core_clk) begin
    if (cold_rst) begin
      cold_seen_reg    <= 1'b0;
      rx_width_reg     <= LCS_W8;
      disc_at_cold_reg <= LCS_FLAG_RST;
    end else if (clk_en) begin
      if (!cold_seen_reg) begin
        cold_seen_reg    <= 1'b1;
        rx_width_reg     <= negotiated_width;              // see RULE1
        disc_at_cold_reg <= (negotiated_width == LCS_WNC);  // see RULE20
      end else if (width_upd) begin
        rx_width_reg <= wd[26:24];                          // see RULE1
      end
    end
  end

  // writable control bits, cold reset
  logic wide_reg, long_reg, float_reg, iso_reg, corrupt_reg, flood_reg;
  always_ff @(posedge core_clk) begin
    if (cold_rst) begin
      wide_reg    <= LCS_FLAG_RST;
      long_reg    <= LCS_FLAG_RST;
      float_reg   <= LCS_FLAG_RST;
      iso_reg     <= LCS_FLAG_RST;
      corrupt_reg <= LCS_FLAG_RST;
      flood_reg   <= LCS_FLAG_RST;
    end else if (clk_en && ctl_wr) begin
      if (avs_byteenable[1]) begin
        wide_reg  <= wd[LCS_WIDE_ADDR_BIT];  // see RULE7
        long_reg  <= wd[LCS_LONG_CTL_BIT];   // see RULE9
        float_reg <= wd[LCS_FLOAT_EN_BIT];   // see RULE10
        iso_reg   <= wd[LCS_ISO_EN_BIT];     // see RULE12
      end
      if (avs_byteenable[0]) begin
        corrupt_reg <= wd[LCS_CORRUPT_BIT];  // see RULE19
        flood_reg   <= wd[LCS_FLOOD_EN_BIT];
      end
    end
  end
  assign wide_addr_pkt_en     = wide_reg;
  assign check_corrupt_inject = corrupt_reg;   // see RULE19

  // active width: warm reset or stop disconnect applies; flow mode: warm reset only
  // warm reset is sys_rst: load pending values on first enabled edge after it
  logic warm_pend_reg;
  always_ff @(posedge core_clk) begin
    if (sys_rst) warm_pend_reg <= 1'b1;
    else if (clk_en) warm_pend_reg <= 1'b0;
  end
  logic [2:0] rx_apply_reg;
  logic       iso_apply_reg;
  always_ff @(posedge core_clk) begin
    if (cold_rst) begin
      rx_apply_reg  <= LCS_W8;
      iso_apply_reg <= LCS_FLAG_RST;
    end else if (clk_en) begin
      if (warm_pend_reg || !cold_seen_reg) begin
        rx_apply_reg  <= cold_seen_reg ? rx_width_reg : negotiated_width; // see RULE4
        iso_apply_reg <= iso_reg;                                         // see RULE12
      end else if (stop_fall) begin
        rx_apply_reg <= rx_width_reg;                                     // see RULE4
      end
    end
  end
  assign rx_width_active = rx_apply_reg;
  assign iso_flow_mode   = iso_apply_reg;

  // width limits
  logic [2:0] tx_width_limit, rx_width_limit;
  assign tx_width_limit = (wide_version & link_ganged) ? LCS_W16 : LCS_W8; // see RULE5
  assign rx_width_limit = (wide_version & link_ganged) ? LCS_W16 : LCS_W8; // see RULE6

  // disconnect tristate
  assign tx_float = stop_asserted & float_reg & ~third_gen_rate; // see RULE10

  // control hold after stop release and peer control seen
  typedef enum logic [1:0] {LCS_IDLE, LCS_WAIT_PEER, LCS_HOLD} lcs_init_t;
  lcs_init_t st_reg;
  logic hold_start, hold_active, hold_done;
  logic [LCS_HOLD_W-1:0] hold_cyc;
  assign hold_cyc = (long_reg & ~third_gen_rate) ? LCS_HOLD_W'(LCS_LONG_CYC)  // see RULE9
                                                 : LCS_HOLD_W'(LCS_SHORT_CYC);
  assign hold_start = (st_reg == LCS_WAIT_PEER) & ctl_s_reg[1] & ~stop_asserted;
  always_ff @(posedge core_clk) begin
    if (sys_rst) st_reg <= LCS_WAIT_PEER;
    else if (clk_en) begin
      unique case (st_reg)
        LCS_IDLE:      if (stop_rise) st_reg <= LCS_WAIT_PEER;
        LCS_WAIT_PEER: if (stop_asserted) st_reg <= LCS_IDLE;
                       else if (ctl_s_reg[1]) st_reg <= LCS_HOLD;
        LCS_HOLD:      if (hold_done || stop_asserted) st_reg <= LCS_IDLE;
      endcase
    end
  end
  lcs_ctl_hold u_hold (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .start      (hold_start),
    .hold_cycles(hold_cyc),
    .hold_active(hold_active),
    .hold_done  (hold_done)
  );
  assign link_ctl_sig = hold_active | (st_reg == LCS_IDLE & ~stop_asserted); // see RULE8

  // init done: sticky through disconnects and retries
  logic init_reg;
  always_ff @(posedge core_clk) begin
    if (cold_rst) init_reg <= LCS_FLAG_RST;
    else if (clk_en && hold_done && init_ok && !disc_at_cold_reg) init_reg <= 1'b1; // see RULE16
  end

  // sticky error flags, set wins over write-one clear
  logic [1:0] err_reg;
  logic       fail_reg;
  logic [1:0] err_set;
  logic       fail_set;
  logic       clr_lo;
  assign clr_lo  = ctl_wr & avs_byteenable[1];
  assign err_set = retry_mode ? {1'b0, uncorrectable_err}   // see RULE15
                              : lane_err_in;
  assign fail_set = (flood_reg & |err_set) | reconnect_fail  // see RULE18
                  | sync_flood_rx | link_unused;
  always_ff @(posedge core_clk) begin
    if (cold_rst) begin
      err_reg  <= LCS_ERR_RST;
      fail_reg <= LCS_FLAG_RST;
    end else if (clk_en) begin
      err_reg  <= (err_reg & ~(clr_lo ? wd[9:8] : 2'h0)) | err_set;              // see RULE14
      fail_reg <= (fail_reg & ~(ctl_wr & avs_byteenable[0] & wd[LCS_LINK_FAIL_BIT]))
                | fail_set;                                                       // see RULE21
    end
  end
  assign sync_flood_tx = flood_reg & |err_reg; // see RULE21

  // read data
  logic [31:0] ctl_word;
  always_comb begin
    ctl_word = '0;
    ctl_word[26:24] = rx_width_reg;
    ctl_word[22:20] = tx_width_limit;
    ctl_word[18:16] = rx_width_limit;
    ctl_word[LCS_WIDE_ADDR_BIT] = wide_reg;
    ctl_word[LCS_LONG_CTL_BIT]  = long_reg;
    ctl_word[LCS_FLOAT_EN_BIT]  = float_reg;
    ctl_word[LCS_ISO_EN_BIT]    = iso_reg;
    ctl_word[9:8]               = err_reg;
    ctl_word[LCS_INIT_DONE_BIT] = init_reg & ~test_mode;  // see RULE17
    ctl_word[LCS_LINK_FAIL_BIT] = fail_reg;
    ctl_word[LCS_CORRUPT_BIT]   = corrupt_reg;
    ctl_word[LCS_FLOOD_EN_BIT]  = flood_reg;
    ctl_word = ctl_word & ~LCS_RSV_MASK;                  // see RULE22
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) avs_readdata <= '0;
    else if (rd_en) begin
      if (hit_ctl) avs_readdata <= ctl_word;
      else if (hit_sts) avs_readdata <= {28'h0, 1'b0, iso_apply_reg, rx_apply_reg[1:0]};
      else avs_readdata <= '0;
    end
  end

  // checks
  err_sticky_a: assert property (@(posedge core_clk) disable iff (sys_rst || cold_rst) // see RULE14
    clk_en && cold_seen_reg && err_set[0] |=> err_reg[0])
    else $error("lane error not captured");
  float_third_gen_rate_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RULE10
    third_gen_rate |-> !tx_float)
    else $error("float at third gen rate");
  limit_ungang_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RULE5
    !link_ganged |-> tx_width_limit == LCS_W8 && rx_width_limit == LCS_W8)
    else $error("limit not eight when unganged");
  width_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst || cold_rst) // see RULE4
    clk_en && cold_seen_reg && !warm_pend_reg && !stop_fall |=> $stable(rx_apply_reg))
    else $error("width changed without disconnect");
  flood_fail_a: assert property (@(posedge core_clk) disable iff (sys_rst || cold_rst) // see RULE21
    clk_en && flood_reg && |err_set |=> fail_reg)
    else $error("flood did not set fail");
  disc_lock_a: assert property (@(posedge core_clk) disable iff (sys_rst || cold_rst) // see RULE3
    clk_en && cold_seen_reg && disc_at_cold_reg |=> $stable(rx_width_reg))
    else $error("disconnected width changed");
  gang16_a: assert property (@(posedge core_clk) disable iff (sys_rst || cold_rst) // see RULE2
    clk_en && ctl_wr && !link_ganged && wd[26:24] == LCS_W16 && cold_seen_reg
      |=> $stable(rx_width_reg))
    else $error("sixteen set while unganged");
  hold_ctl_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RULE8
    hold_start && clk_en |=> link_ctl_sig)
    else $error("control not held");
  init_keep_a: assert property (@(posedge core_clk) disable iff (cold_rst) // see RULE17
    clk_en && init_reg |=> init_reg)
    else $error("init done bit lost");
endmodule
`default_nettype wire

// >>> lcs_peer_model.sv
// peer device model: answers the control handshake and reports init success
`timescale 1ns/1ps
`default_nettype none
module lcs_peer_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // test control
  input  wire logic go,
  // link wires
  input  wire logic link_ctl_sig,
  output logic      peer_ctl_in,
  output logic      init_ok
);
  logic seen_reg;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !go) begin
      peer_ctl_in <= 1'b0;
      seen_reg    <= 1'b0;
      init_ok     <= 1'b0;
    end else begin
      peer_ctl_in <= 1'b1;
      if (link_ctl_sig) begin
        seen_reg <= 1'b1;
      end
      // level, so it still stands when the hold timer finishes
      init_ok <= seen_reg;
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the link control and status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module testbench;
  import lcs_pkg::*;
  logic        core_clk, sys_rst, cold_rst, avs_read, avs_write, avs_waitrequest, peer_go;
  logic        link_ganged, wide_version, third_gen_rate, link_unused, link_stop_n;
  logic        peer_ctl_in, retry_mode, uncorrectable_err, reconnect_fail, sync_flood_rx;
  logic        init_ok, test_mode, iso_flow_mode, wide_addr_pkt_en, link_ctl_sig, tx_float;
  logic        check_corrupt_inject, sync_flood_tx;
  logic [1:0]  lane_err_in;
  logic [2:0]  negotiated_width, rx_width_active;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          err_total, check_count;
  lcs_link_ctrl i_lcs_link_ctrl (.core_clk(core_clk), .sys_rst(sys_rst), .cold_rst(cold_rst),
    .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_ganged(link_ganged), .wide_version(wide_version),
    .negotiated_width(negotiated_width), .third_gen_rate(third_gen_rate),
    .link_unused(link_unused), .link_stop_n(link_stop_n), .peer_ctl_in(peer_ctl_in),
    .retry_mode(retry_mode), .lane_err_in(lane_err_in), .uncorrectable_err(uncorrectable_err),
    .reconnect_fail(reconnect_fail), .sync_flood_rx(sync_flood_rx), .init_ok(init_ok),
    .test_mode(test_mode), .rx_width_active(rx_width_active), .iso_flow_mode(iso_flow_mode),
    .wide_addr_pkt_en(wide_addr_pkt_en), .link_ctl_sig(link_ctl_sig), .tx_float(tx_float),
    .check_corrupt_inject(check_corrupt_inject), .sync_flood_tx(sync_flood_tx));
  lcs_peer_model i_lcs_peer_model (.core_clk(core_clk), .sys_rst(sys_rst), .go(peer_go),
    .link_ctl_sig(link_ctl_sig), .peer_ctl_in(peer_ctl_in), .init_ok(init_ok));
  always #25 core_clk = ~core_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    r = avs_readdata;
    if (n >= 40) begin
      err_total++;
      $display("[ERR] %0t bus timeout", $time);
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, LCS_LINK_CONTROL_OFF, d, x);
  endtask
  task automatic rd(output logic [31:0] r);
    bus(1'b0, LCS_LINK_CONTROL_OFF, 32'h0, r);
  endtask
  task automatic do_reset(input logic cold);
    @(posedge core_clk);
    sys_rst  <= 1'b1;
    cold_rst <= cold;
    cyc(6);
    sys_rst  <= 1'b0;
    cold_rst <= 1'b0;
    cyc(3);
  endtask
  task automatic stop_pulse;
    @(posedge core_clk);
    link_stop_n <= 1'b0;
    cyc(6);
    link_stop_n <= 1'b1;
    cyc(6);
  endtask
  task automatic pulse_ev(input int k, input logic [1:0] v);
    @(posedge core_clk);
    lane_err_in       <= (k == 0) ? v : 2'h0;
    uncorrectable_err <= (k == 1);
    reconnect_fail    <= (k == 2);
    sync_flood_rx     <= (k == 3);
    link_unused       <= (k == 4);
    @(posedge core_clk);
    lane_err_in       <= 2'h0;
    uncorrectable_err <= 1'b0;
    reconnect_fail    <= 1'b0;
    sync_flood_rx     <= 1'b0;
    link_unused       <= 1'b0;
    cyc(2);
  endtask
  task automatic t_regs;
    rd(q);
    `CHK(q & 32'h8FFF_FFFF, 32'h0011_0000)
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      link_ganged  <= i[0];
      wide_version <= i[1];
      rd(q);
      `CHK(q[22:20], (i == 3) ? LCS_W16 : LCS_W8)
      `CHK(q[18:16], (i == 3) ? LCS_W16 : LCS_W8)
    end
    wr(32'h88FF_FFFF);
    rd(q);
    `CHK(q & 32'h8888_0CC5, 32'h0)
    `CHK({q[15:12], q[3], q[1]}, 6'h3F)
    `CHK({wide_addr_pkt_en, check_corrupt_inject, iso_flow_mode}, 3'h6)
    do_reset(1'b0);
    `CHK(iso_flow_mode, 1'b1)
    bus(1'b0, LCS_LINK_STATUS_OFF, 32'h0, q);
    `CHK(q[2], 1'b1)
    bus(1'b0, 8'h90, 32'h0, q);
    `CHK(q, 32'h0)
    wr(32'h0);
    `CHK({wide_addr_pkt_en, check_corrupt_inject}, 2'h0)
  endtask
  task automatic t_width;
    wr(32'h0100_0000);
    rd(q);
    `CHK(q[26:24], LCS_W16)
    `CHK(rx_width_active, LCS_W8)
    do_reset(1'b0);
    `CHK(rx_width_active, LCS_W16)
    wr(32'h0);
    `CHK(rx_width_active, LCS_W16)
    stop_pulse();
    `CHK(rx_width_active, LCS_W8)
    @(posedge core_clk);
    link_ganged <= 1'b0;
    wr(32'h0100_0000);
    rd(q);
    `CHK(q[26:24], LCS_W8)
    link_ganged <= 1'b1;
  endtask
  task automatic t_float(input logic en, input logic g3, input logic exp);
    wr({18'h0, en, 13'h0});
    third_gen_rate <= g3;
    link_stop_n    <= 1'b0;
    cyc(6);
    @(negedge core_clk);
    `CHK(tx_float, exp)
    stop_pulse();
    third_gen_rate <= 1'b0;
  endtask
  task automatic t_errs;
    pulse_ev(0, 2'h2);
    rd(q);
    `CHK({q[9:8], q[4]}, 3'h4)
    wr(32'h200);
    rd(q);
    `CHK(q[9:8], 2'h0)
    retry_mode <= 1'b1;
    pulse_ev(0, 2'h3);
    rd(q);
    `CHK(q[9:8], 2'h0)
    pulse_ev(1, 2'h0);
    rd(q);
    `CHK(q[9:8], 2'h1)
    retry_mode <= 1'b0;
    wr(32'h102);
    pulse_ev(0, 2'h1);
    rd(q);
    `CHK({q[9:8], q[4], sync_flood_tx}, 4'h7)
    wr(32'h312);
    wr(32'h0);
    for (int k = 2; k < 5; k++) begin
      pulse_ev(k, 2'h0);
      rd(q);
      `CHK(q[4], 1'b1)
      wr(32'h10);
      rd(q);
      `CHK(q[4], 1'b0)
    end
  endtask
  task automatic t_hold(input logic lng, input logic g3);
    int n;
    logic hi;
    n  = 0;
    hi = 1'b0;
    wr({17'h0, lng, 14'h0});
    third_gen_rate <= g3;
    stop_pulse();
    peer_go <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
      if (link_ctl_sig === 1'b1) hi = 1'b1;
    end while (!(hi && link_ctl_sig === 1'b0) && n < 1200);
    `CHK(hi, 1'b1)
    if (lng && !g3) `CHK(n >= LCS_LONG_CYC, 1'b1)
    else `CHK(n >= LCS_SHORT_CYC && n < LCS_LONG_CYC, 1'b1)
    cyc(5);
    rd(q);
    `CHK(q[5], 1'b1)
    peer_go        <= 1'b0;
    third_gen_rate <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    {core_clk, sys_rst, cold_rst, avs_read, avs_write, peer_go} = 6'h18;
    {link_ganged, wide_version, third_gen_rate, link_unused, link_stop_n} = 5'h19;
    {retry_mode, uncorrectable_err, reconnect_fail, sync_flood_rx, test_mode} = 5'h0;
    lane_err_in      = 2'h0;
    negotiated_width = LCS_W8;
    avs_address      = 8'h0;
    avs_writedata    = 32'h0;
    err_total        = 0;
    check_count      = 0;
    do_reset(1'b1);
    t_regs();
    t_width();
    t_float(1'b1, 1'b0, 1'b1);
    t_float(1'b0, 1'b0, 1'b0);
    t_float(1'b1, 1'b1, 1'b0);
    t_errs();
    t_hold(1'b0, 1'b0);
    test_mode <= 1'b1;
    rd(q);
    `CHK(q[5], 1'b0)
    test_mode <= 1'b0;
    stop_pulse();
    rd(q);
    `CHK(q[5], 1'b1)
    t_hold(1'b1, 1'b0);
    t_hold(1'b1, 1'b1);
    negotiated_width <= LCS_WNC;
    do_reset(1'b1);
    wr(32'h0);
    rd(q);
    `CHK(q[26:24], LCS_WNC)
    tally_and_finish();
  end
endmodule
`default_nettype wire
